// *** pkg/hport_pkg.sv ***
/*
 * Shared constants for the parallel host port of the time-slot
 * switch: bus widths, timing figures and derived cycle counts.
 * Assumes a single 10 MHz clock common to both ends.
 */
package hport_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int NUM_STREAMS = 16;
   localparam int REG_DEPTH = 4096;
   localparam int CLK_HZ = 10_000_000;
   // Reset hold time in microseconds (least), and post-release wait.
   localparam int RESET_HOLD_US = 1000;
   localparam int POST_RESET_WAIT_US = 600;
   localparam int RESET_HOLD_CYC = (RESET_HOLD_US * (CLK_HZ / 1_000_000)) + 1;
   localparam int POST_RESET_WAIT_CYC = POST_RESET_WAIT_US * (CLK_HZ / 1_000_000);
   localparam int CNT_W = 16;
   localparam logic [DATA_W-1:0] REG_RESET_VAL = 16'h0000;
   localparam logic [NUM_STREAMS-1:0] HIZ_CTRL_ALL_HIGH = 16'hffff;
   // Read/write line level for a read access.
   localparam logic RW_READ = 1'b1;
endpackage

// *** pkg/hport_if.sv ***
/*
 * Wires of the host port between the host and the switch device.
 * Assumes the bench resolves the shared data bus and the pulled-up
 * acknowledge from the output enables of both ends.
 */
interface hport_if;
   import hport_pkg::*;
   logic [ADDR_W-1:0] host_address_bus;
   logic chip_sel_n;
   logic data_strobe_n;
   logic read_write;
   logic [DATA_W-1:0] host_data_to_dev;
   logic [DATA_W-1:0] dev_data_to_host;
   logic dev_data_oe;
   logic host_data_oe;
   logic transfer_ack_n;
   logic transfer_ack_oe;
   logic dev_reset_n;
   modport device (
      input host_address_bus, chip_sel_n, data_strobe_n, read_write,
      input host_data_to_dev, dev_reset_n,
      output dev_data_to_host, dev_data_oe, transfer_ack_n, transfer_ack_oe
   );
   modport host (
      output host_address_bus, chip_sel_n, data_strobe_n, read_write,
      output host_data_to_dev, host_data_oe, dev_reset_n,
      input dev_data_to_host, transfer_ack_n, transfer_ack_oe
   );
endinterface

// *** hdl/hport_device.sv ***
/*
 * Device end of the host port: a 4096-word register space reached by the
 * host, acknowledge generation, and the reset behaviour of the serial
 * output drivers and high-impedance control outputs.
 * Assumes the host keeps its timing; control pins pass two flip-flops first.
 */
// Overview of operation
// - 12-bit address selects internal registers.
// - 16-bit shared bidirectional data bus.
// - Acknowledge driven low only on completion.
// - Chip select low enables; high ignored.
// - Read/write line sets data direction.
// - Access only with strobe and select low.
// - Reset disables outputs, hiz controls high.
// - Reset clears registers and counters.
// - Reset held low longer than 1 ms.
// - Host waits 600 us after reset.
module hport_device (
   input wire logic mclk_i,
   hport_if.device bus,
   input wire logic [hport_pkg::NUM_STREAMS-1:0] stream_data_i,
   output logic [hport_pkg::NUM_STREAMS-1:0] serial_output_stream_o,
   output logic [hport_pkg::NUM_STREAMS-1:0] serial_output_stream_oe_o,
   output logic [hport_pkg::NUM_STREAMS-1:0] serial_out_hiz_ctrl_o,
   output logic [hport_pkg::CNT_W-1:0] access_count_o
);
   import hport_pkg::*;

   typedef enum logic [1:0] {IDLE, ACCESS, ACKED} dev_state_t;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] cs_sync_r;
   logic [1:0] ds_sync_r;
   logic [1:0] rw_sync_r;
   logic resetn;

   assign resetn = bus.dev_reset_n;

   always_ff @(posedge mclk_i or negedge resetn) begin
      if (!resetn) begin
         cs_sync_r <= 2'h3;
         ds_sync_r <= 2'h3;
         rw_sync_r <= 2'h3;
      end else begin
         cs_sync_r <= {cs_sync_r[0], bus.chip_sel_n};
         ds_sync_r <= {ds_sync_r[0], bus.data_strobe_n};
         rw_sync_r <= {rw_sync_r[0], bus.read_write};
      end
   end

   logic sel_active;
   assign sel_active = !cs_sync_r[1] && !ds_sync_r[1];

   // ----------------------------------------------------------------
   // Access control
   // ----------------------------------------------------------------
   // Address and write data are held stable by the host through the
   // strobe, so they are sampled only after the synchronised strobe,
   // which already trails the pins by two cycles.
   logic [DATA_W-1:0] regs_r [REG_DEPTH];
   dev_state_t state_r, state_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic ack_r, ack_nxt;
   logic drive_r, drive_nxt;
   logic [CNT_W-1:0] count_r, count_nxt;
   logic wr_en;

   always_comb begin
      state_nxt = state_r;
      rdata_nxt = rdata_r;
      ack_nxt = ack_r;
      drive_nxt = drive_r;
      count_nxt = count_r;
      wr_en = 1'b0;
      unique case (state_r)
         IDLE: begin
            if (sel_active) begin
               state_nxt = ACCESS;
            end
         end
         ACCESS: begin
            if (!sel_active) begin
               state_nxt = IDLE;
            end else if (rw_sync_r[1] == RW_READ) begin
               rdata_nxt = regs_r[bus.host_address_bus];
               drive_nxt = 1'b1;
               ack_nxt = 1'b1;
               count_nxt = count_r + 16'h0001;
               state_nxt = ACKED;
            end else begin
               wr_en = 1'b1;
               ack_nxt = 1'b1;
               count_nxt = count_r + 16'h0001;
               state_nxt = ACKED;
            end
         end
         ACKED: begin
            if (!sel_active) begin
               ack_nxt = 1'b0;
               drive_nxt = 1'b0;
               state_nxt = IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge resetn) begin
      if (!resetn) begin
         state_r <= IDLE;
         rdata_r <= REG_RESET_VAL;
         ack_r <= 1'b0;
         drive_r <= 1'b0;
         count_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         rdata_r <= rdata_nxt;
         ack_r <= ack_nxt;
         drive_r <= drive_nxt;
         count_r <= count_nxt;
      end
   end

   // The register space is a memory; reset clears it one word per cycle
   // after release, since an array cannot be cleared under async reset.
   logic [ADDR_W:0] clr_idx_r, clr_idx_nxt;

   always_comb begin
      clr_idx_nxt = clr_idx_r;
      if (!clr_idx_r[ADDR_W]) begin
         clr_idx_nxt = clr_idx_r + 13'h0001;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn) begin
      if (!resetn) begin
         clr_idx_r <= 13'h0000;
      end else begin
         clr_idx_r <= clr_idx_nxt;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!clr_idx_r[ADDR_W]) begin
         regs_r[clr_idx_r[ADDR_W-1:0]] <= REG_RESET_VAL;
      end else if (wr_en) begin
         regs_r[bus.host_address_bus] <= bus.host_data_to_dev;
      end
   end

   assign bus.transfer_ack_n = 1'b0;
   assign bus.transfer_ack_oe = ack_r;
   assign bus.dev_data_to_host = rdata_r;
   assign bus.dev_data_oe = drive_r;
   assign access_count_o = count_r;

   // ----------------------------------------------------------------
   // Serial outputs
   // ----------------------------------------------------------------
   // Register word 0 enables the stream drivers, one bit per stream.
   logic [NUM_STREAMS-1:0] sdata_r;

   always_ff @(posedge mclk_i or negedge resetn) begin
      if (!resetn) begin
         sdata_r <= 16'h0000;
      end else begin
         sdata_r <= stream_data_i;
      end
   end

   logic [NUM_STREAMS-1:0] stream_en;
   assign stream_en = clr_idx_r[ADDR_W] ? regs_r[0] : 16'h0000;

   assign serial_output_stream_o = sdata_r;
   assign serial_output_stream_oe_o = resetn ? stream_en : 16'h0000;
   assign serial_out_hiz_ctrl_o = resetn ? ~stream_en : HIZ_CTRL_ALL_HIGH;
endmodule

// *** hdl/hport_host.sv ***
/*
 * Host end of the port: holds the device in reset, waits out the
 * stabilisation time, then runs single read or write transfers.
 * Assumes the device acknowledge is pulled up when nobody drives it.
 */
module hport_host #(
   parameter int RESET_HOLD = hport_pkg::RESET_HOLD_CYC,
   parameter int POST_WAIT = hport_pkg::POST_RESET_WAIT_CYC
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   hport_if.host bus,
   input wire logic req_i,
   input wire logic req_write_i,
   input wire logic [hport_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [hport_pkg::DATA_W-1:0] req_wdata_i,
   output logic ready_o,
   output logic done_o,
   output logic [hport_pkg::DATA_W-1:0] rdata_o
);
   import hport_pkg::*;

   typedef enum logic [2:0] {RST, WAIT, IDLE, STROBE, RELEASE} host_state_t;

   // ----------------------------------------------------------------
   // Acknowledge synchroniser
   // ----------------------------------------------------------------
   logic [1:0] ack_sync_r;
   logic ack_pin;
   assign ack_pin = bus.transfer_ack_oe ? bus.transfer_ack_n : 1'b1;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_sync_r <= 2'h3;
      end else begin
         ack_sync_r <= {ack_sync_r[0], ack_pin};
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   host_state_t state_r, state_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic wr_r, wr_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0] wdata_r, wdata_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic done_r, done_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      wr_nxt = wr_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      done_nxt = 1'b0;
      unique case (state_r)
         RST: begin
            if (cnt_r >= 32'(RESET_HOLD)) begin
               cnt_nxt = 32'h0;
               state_nxt = WAIT;
            end else begin
               cnt_nxt = cnt_r + 32'h1;
            end
         end
         WAIT: begin
            if (cnt_r >= 32'(POST_WAIT)) begin
               state_nxt = IDLE;
            end else begin
               cnt_nxt = cnt_r + 32'h1;
            end
         end
         IDLE: begin
            if (req_i) begin
               wr_nxt = req_write_i;
               addr_nxt = req_addr_i;
               wdata_nxt = req_wdata_i;
               state_nxt = STROBE;
            end
         end
         STROBE: begin
            if (!ack_sync_r[1]) begin
               if (!wr_r) begin
                  rdata_nxt = bus.dev_data_to_host;
               end
               done_nxt = 1'b1;
               state_nxt = RELEASE;
            end
         end
         RELEASE: begin
            if (ack_sync_r[1]) begin
               state_nxt = IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= RST;
         cnt_r <= 32'h0;
         wr_r <= 1'b0;
         addr_r <= 12'h000;
         wdata_r <= 16'h0000;
         rdata_r <= 16'h0000;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         wr_r <= wr_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
         done_r <= done_nxt;
      end
   end

   logic strobing;
   assign strobing = (state_r == STROBE);
   // Address, direction and data settle in IDLE-to-STROBE; the device
   // samples them only after its two-stage strobe synchroniser.
   assign bus.dev_reset_n = (state_r != RST);
   assign bus.chip_sel_n = !strobing;
   assign bus.data_strobe_n = !strobing;
   assign bus.read_write = wr_r ? !RW_READ : RW_READ;
   assign bus.host_address_bus = addr_r;
   assign bus.host_data_to_dev = wdata_r;
   assign bus.host_data_oe = strobing && wr_r;
   assign ready_o = (state_r == IDLE);
   assign done_o = done_r;
   assign rdata_o = rdata_r;
endmodule

// *** tb/hport_monitor.sv ***
/*
 * Checker on the host port wires between the host end and the device end.
 * Assumes one clock, and the device reset carried on the interface.
 */
module hport_monitor (
   input wire logic mclk_i,
   input wire logic dev_reset_n,
   input wire logic chip_sel_n,
   input wire logic data_strobe_n,
   input wire logic read_write,
   input wire logic [hport_pkg::ADDR_W-1:0] host_address_bus,
   input wire logic host_data_oe,
   input wire logic dev_data_oe,
   input wire logic transfer_ack_n,
   input wire logic transfer_ack_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   import hport_pkg::*;
   logic acc;
   assign acc = !chip_sel_n && !data_strobe_n;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!dev_reset_n);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // The acknowledge may only be pulled low during an access or while it is released.
   ack_low_value_a: assert property (transfer_ack_oe |-> !transfer_ack_n && ($past(acc, 1) || $past(acc, 3)))
      else $error("ack driven outside an access");
   // Two synchroniser stages, the idle-to-access step, then the acknowledge register.
   ack_latency_a: assert property ($rose(acc) |-> !transfer_ack_oe ##4 transfer_ack_oe)
      else $error("ack not four cycles after access start");
   ack_cause_a: assert property ($rose(transfer_ack_oe) |-> $past(acc, 1) && $past(acc, 2))
      else $error("ack raised without select and strobe");
   ack_release_a: assert property ($fell(acc) |-> ##3 !transfer_ack_oe && !dev_data_oe)
      else $error("ack or data not released");
   read_drive_a: assert property (dev_data_oe && acc |-> read_write == RW_READ)
      else $error("device drives data on a write");
   write_drive_a: assert property (host_data_oe |-> read_write != RW_READ)
      else $error("host drives data on a read");
   no_contention_a: assert property (!(host_data_oe && dev_data_oe))
      else $error("both ends drive the data bus");
   addr_hold_a: assert property (acc && $past(acc) |-> $stable(host_address_bus))
      else $error("address moved during access");
   reset_clear_a: assert property ($rose(dev_reset_n) |-> !transfer_ack_oe && !dev_data_oe)
      else $error("outputs active after reset");
   cov_read_c: cover property ($rose(transfer_ack_oe) && read_write);
   cov_write_c: cover property ($rose(transfer_ack_oe) && !read_write);
   cov_reset_c: cover property ($rose(dev_reset_n));
endmodule

// *** tb/tdm_switch_host_port_tb_top.sv ***
/*
 * Bench joining the host end and the device end of the host port.
 * Assumes the host keeps its full reset hold and post-reset wait figures.
 */
module tdm_switch_host_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import hport_pkg::*;
   logic mclk_i;
   logic resetn_i;
   logic req_i;
   logic req_write_i;
   logic [ADDR_W-1:0] req_addr_i;
   logic [DATA_W-1:0] req_wdata_i;
   logic [NUM_STREAMS-1:0] stream_data_i;
   logic ready_o;
   logic done_o;
   logic [DATA_W-1:0] rdata_o;
   logic [NUM_STREAMS-1:0] so;
   logic [NUM_STREAMS-1:0] so_oe;
   logic [NUM_STREAMS-1:0] hiz;
   logic [CNT_W-1:0] acc_cnt;
   logic [ADDR_W-1:0] addrs [4] = '{12'h001, 12'h7ff, 12'h800, 12'hfff};
   logic [DATA_W-1:0] datas [4] = '{16'ha5a5, 16'h5a5a, 16'hffff, 16'h0001};
   int err_count = 0;
   int n_compared = 0;
   hport_if bus ();
   hport_host u_hport_host (.mclk_i(mclk_i),
      .resetn_i(resetn_i), .bus(bus.host), .req_i(req_i), .req_write_i(req_write_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .ready_o(ready_o),
      .done_o(done_o), .rdata_o(rdata_o));
   hport_device u_hport_device (.mclk_i(mclk_i), .bus(bus.device),
      .stream_data_i(stream_data_i), .serial_output_stream_o(so),
      .serial_output_stream_oe_o(so_oe), .serial_out_hiz_ctrl_o(hiz),
      .access_count_o(acc_cnt));
   hport_monitor u_hport_monitor (.mclk_i(mclk_i), .dev_reset_n(bus.dev_reset_n),
      .chip_sel_n(bus.chip_sel_n), .data_strobe_n(bus.data_strobe_n),
      .read_write(bus.read_write), .host_address_bus(bus.host_address_bus),
      .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe),
      .transfer_ack_n(bus.transfer_ack_n), .transfer_ack_oe(bus.transfer_ack_oe));
   // ------------------------------------------------------------
   // Clock, stream stimulus and tasks
   // ------------------------------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      stream_data_i <= stream_data_i + 16'h0001;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One transfer: request held until the edge that sees ready, then wait for done.
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 100) begin
         @(posedge mclk_i);
         n++;
      end
      check(ready_o, 1'b1, "host ready for request");
      req_i <= 1'b1;
      req_write_i <= wr;
      req_addr_i <= a;
      req_wdata_i <= d;
      @(posedge mclk_i);
      req_i <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (done_o !== 1'b1 && n < 50);
      q = rdata_o;
      check(n < 50, 1, "transfer completes");
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic [15:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      logic [15:0] q;
      xfer(1'b0, a, 16'h0000, q);
      check(q, exp, "read data");
   endtask
   // Reset, check the quiet state, then wait for the host to become ready.
   // The device clears its words well within the host's post-reset wait.
   task automatic do_reset();
      int n;
      int n_low;
      n = 0;
      n_low = 0;
      resetn_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      check(hiz, HIZ_CTRL_ALL_HIGH, "hiz in reset");
      check(so_oe, 16'h0000, "stream enables in reset");
      resetn_i <= 1'b1;
      while (ready_o !== 1'b1 && n < 20000) begin
         @(posedge mclk_i);
         n++;
         if (bus.dev_reset_n === 1'b0) n_low++;
      end
      check(n_low >= RESET_HOLD_CYC, 1, "device reset held long enough");
      check(n >= RESET_HOLD_CYC + POST_RESET_WAIT_CYC, 1, "first access after wait");
      check(ready_o, 1'b1, "host ready after reset");
      check(acc_cnt, 16'h0000, "access count cleared");
      check(hiz, HIZ_CTRL_ALL_HIGH, "hiz after clear");
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      resetn_i = 1'b0;
      req_i = 1'b0;
      req_write_i = 1'b0;
      req_addr_i = 12'h000;
      req_wdata_i = 16'h0000;
      stream_data_i = 16'h0000;
      do_reset();
      rd(12'h005, REG_RESET_VAL);
      for (int i = 0; i < 4; i++) wr(addrs[i], datas[i]);
      for (int i = 0; i < 4; i++) rd(addrs[i], datas[i]);
      check(acc_cnt, 16'h0009, "completed access count");
      wr(12'h000, 16'h00f0);
      check(so_oe, 16'h00f0, "stream enables follow word 0");
      check(hiz, 16'hff0f, "hiz is inverse of enables");
      check(so, 16'(stream_data_i - 16'h0001), "stream data one cycle late");
      rd(12'h000, 16'h00f0);
      do_reset();
      rd(12'hfff, REG_RESET_VAL);
      rd(12'h000, REG_RESET_VAL);
      conclude();
   end
   initial begin
      #4_000_000;
      err_count++;
      conclude();
   end
endmodule
